// ### iac_ctrl.sv
// Function
// - Slave address is 10010 followed by the two strap pin levels.
// - Straps sampled once, first transaction, at rise starting eighth pulse; kept after.
// - Strap codes 00..11 give addresses 0x48..0x4B.
// - SDA falling while SCL high is START; prepare to shift eight bits.
// - Seven address bits MSB first, then direction bit, shifted in order.
// - Matching address is acknowledged in ninth pulse; otherwise stay off bus until START.
// - Direction 0 means master writes, 1 means master reads.
// - Each byte is eight data pulses plus one acknowledge pulse from receiver.
// - SDA changes only with SCL low; SDA rising while SCL high is STOP.
// - No limit on number of bytes in one transfer.
// - Command: bit7 input type, bits6-4 channel, bits3-2 power, bits1-0 ignored.
// - Input type 0 is differential, 1 is single-ended against common.
// - Power field: 00 down between, 01 converter on, 10 reference, 11 both.
// - Differential: low channel bits pick pair; bit2 swaps polarity.
// - Single-ended: codes 0-3 pick even inputs, 4-7 odd; common negative.
// - Conversion starts once type and channel bits arrive, before byte ends.
// - Command byte acknowledged; a read then returns the result.
// - Read returns eight result bits, MSB first.
// - One result bit decided per step from top, held in approximation register.
// - Idle and unaddressed: converter core off unless command bit2 is set, internal clock gated.
// - Bus works at 100 kHz, 400 kHz and 3.4 MHz.
// - High-speed read holds SCL low until conversion is done.
// - STOP leaves high-speed mode; repeated START keeps it.
// - Internal reference stays off until a command turns it on.
module iac_ctrl (
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  input  wire logic              ce_in,
  input  wire logic              scl_clk_in,
  input  wire logic              sda_in,
  input  wire logic              addr_strap_hi_in,
  input  wire logic              addr_strap_lo_in,
  input  wire logic              comparator_in,
  output logic                   sda_out,
  output logic                   sda_oe_out,
  output logic                   scl_out,
  output logic                   scl_oe_out,
  output logic [7:0]             dac_code_out,
  output iac_pkg::iac_mux_s      mux_sel_out,
  output logic                   adc_power_out,
  output logic                   ref_on_out,
  output logic                   conv_clk_en_out,
  output logic                   conv_busy_out,
  output logic                   hs_mode_out
);

  // Link domain: SDA captured on each SCL rise
  logic                  sda_cap_reg;

  logic [5:0]            async_w;
  logic [5:0]            sy1_reg;
  logic [5:0]            sy2_reg;
  logic [1:0]            prev_reg;
  logic                  rise_d_reg;
  logic                  low_reg;

  iac_pkg::iac_state_e   state_reg;
  iac_pkg::iac_state_e   state_next;
  logic [3:0]            cnt_reg;
  logic [3:0]            cnt_next;
  logic [7:0]            sh_reg;
  logic [7:0]            tx_reg;
  logic [1:0]            strap_reg;
  logic                  strap_valid_reg;
  logic                  hs_reg;
  logic                  stretch_reg;
  logic                  sda_oe_reg;
  logic                  sda_oe_next;
  iac_pkg::iac_cmd_s     cmd_reg;
  iac_pkg::iac_mux_s     mux_reg;
  logic                  conv_busy_reg;
  logic [2:0]            tim_reg;
  logic [7:0]            sar_reg;
  logic [7:0]            mask_reg;
  logic [7:0]            result_reg;
  logic                  adc_power_reg;
  logic                  ref_on_reg;
  logic                  clk_en_reg;

  always_ff @(posedge scl_clk_in) begin
    sda_cap_reg <= sda_in;
  end

  assign async_w = {comparator_in, addr_strap_lo_in, addr_strap_hi_in, sda_cap_reg, sda_in, scl_clk_in};

  // Two-flop synchronisers, fast enough for 3.4 MHz at 40 MHz
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sy1_reg  <= iac_pkg::SYNC_RESET;
      sy2_reg  <= iac_pkg::SYNC_RESET;
      prev_reg <= iac_pkg::SYNC_RESET[1:0];
    end else if (ce_in) begin
      sy1_reg  <= async_w;
      sy2_reg  <= sy1_reg;
      prev_reg <= sy2_reg[1:0];
    end
  end

  wire scl_now   = sy2_reg[iac_pkg::SY_SCL];
  wire sda_now   = sy2_reg[iac_pkg::SY_SDA];
  wire scl_was   = prev_reg[iac_pkg::SY_SCL];
  wire sda_was   = prev_reg[iac_pkg::SY_SDA];
  wire bit_val   = sy2_reg[iac_pkg::SY_CAP];
  wire cmp_now   = sy2_reg[iac_pkg::SY_CMP];
  wire scl_rise  = scl_now & ~scl_was;
  wire scl_fall  = ~scl_now & scl_was;
  wire start_ev  = scl_now & scl_was & sda_was & ~sda_now;
  wire stop_ev   = scl_now & scl_was & ~sda_was & sda_now;
  // Captured bit is read one cycle after the rise so both syncs agree
  wire bit_take  = rise_d_reg;

  wire       on_bus    = state_reg != iac_pkg::ST_IDLE;
  wire       in_read   = state_reg == iac_pkg::ST_READ;
  wire       in_write  = state_reg == iac_pkg::ST_WRITE;
  wire       in_addr   = state_reg == iac_pkg::ST_ADDR;
  wire       ack_fall  = scl_fall && on_bus && cnt_reg == iac_pkg::CNT_ACK;
  wire       end_fall  = scl_fall && cnt_reg == iac_pkg::CNT_END;
  wire       data_fall = scl_fall && in_read && cnt_reg != iac_pkg::CNT_ZERO && cnt_reg < iac_pkg::CNT_ACK;
  wire [6:0] own_addr  = {iac_pkg::ADDR_PREFIX, strap_reg};
  wire       addr_match = sh_reg[7:1] == own_addr;
  wire       hs_code   = sh_reg[7:3] == iac_pkg::HS_CODE_TOP;
  wire       ack_drive = (in_addr && addr_match) || in_write;
  wire [3:0] nib       = {sh_reg[2:0], bit_val};
  wire       conv_start = bit_take && in_write && cnt_reg == iac_pkg::CNT_NIBBLE;
  wire       cmd_done  = bit_take && in_write && cnt_reg == iac_pkg::CNT_STRAP;
  wire       master_nack = bit_take && in_read && cnt_reg == iac_pkg::CNT_ACK && bit_val;
  wire       stretch_set = end_fall && in_read && conv_busy_reg;
  wire       load_tx   = !conv_busy_reg && ((end_fall && in_read && !stretch_reg) || stretch_reg);
  // Clock held until the first read bit already stands on SDA
  wire       tx_ready  = sda_oe_reg == ~result_reg[7];
  wire       strap_take = bit_take && in_addr && cnt_reg == iac_pkg::CNT_STRAP && !strap_valid_reg;

  // Channel decode: positive input is the same in both input types
  wire [2:0] pos_sel   = {nib[1:0], nib[2]};
  wire [2:0] neg_sel   = nib[3] ? 3'h0 : {nib[1:0], ~nib[2]};
  wire [7:0] sar_decided = (sar_reg & ~mask_reg) | (cmp_now ? mask_reg : 8'h00);
  wire       step_end  = conv_busy_reg && tim_reg == iac_pkg::STEP_LAST;
  wire       conv_last = step_end && mask_reg == iac_pkg::SAR_LAST;

  always_comb begin
    state_next = state_reg;
    if (stop_ev) begin
      state_next = iac_pkg::ST_IDLE;
    end else if (start_ev) begin
      state_next = iac_pkg::ST_ADDR;
    end else begin
      case (state_reg)
        iac_pkg::ST_ADDR: begin
          if (ack_fall && !addr_match) begin
            state_next = iac_pkg::ST_IDLE;
          end else if (ack_fall) begin
            state_next = sh_reg[0] ? iac_pkg::ST_READ : iac_pkg::ST_WRITE;
          end
        end
        iac_pkg::ST_READ: begin
          if (master_nack) begin
            state_next = iac_pkg::ST_IDLE;
          end
        end
        iac_pkg::ST_IDLE, iac_pkg::ST_WRITE: begin
          state_next = state_reg;
        end
        default: begin
          state_next = iac_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    cnt_next = cnt_reg;
    if (start_ev) begin
      cnt_next = iac_pkg::CNT_ZERO;
    end else if (end_fall) begin
      cnt_next = iac_pkg::CNT_ZERO;
    end else if (bit_take && on_bus && cnt_reg < iac_pkg::CNT_END) begin
      cnt_next = 4'(cnt_reg + 4'h1);
    end
  end

  always_comb begin
    sda_oe_next = sda_oe_reg;
    if (start_ev || stop_ev) begin
      sda_oe_next = 1'b0;
    end else if (ack_fall) begin
      sda_oe_next = ack_drive;
    end else if (load_tx) begin
      sda_oe_next = ~result_reg[7];
    end else if (end_fall) begin
      sda_oe_next = 1'b0;
    end else if (data_fall) begin
      sda_oe_next = ~tx_reg[6];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_reg  <= iac_pkg::ST_IDLE;
      cnt_reg    <= iac_pkg::CNT_ZERO;
      sda_oe_reg <= 1'b0;
      rise_d_reg <= 1'b0;
      low_reg    <= 1'b0;
    end else if (ce_in) begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      sda_oe_reg <= sda_oe_next;
      rise_d_reg <= scl_rise;
      low_reg    <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sh_reg <= iac_pkg::CMD_RESET;
      tx_reg <= iac_pkg::RESULT_RESET;
    end else if (ce_in) begin
      if (bit_take && cnt_reg < iac_pkg::CNT_ACK) begin
        sh_reg <= {sh_reg[6:0], bit_val};
      end
      if (load_tx) begin
        tx_reg <= result_reg;
      end else if (data_fall) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      strap_reg       <= 2'h0;
      strap_valid_reg <= 1'b0;
    end else if (ce_in && strap_take) begin
      strap_reg       <= {sy2_reg[iac_pkg::SY_STRAP_HI], sy2_reg[iac_pkg::SY_STRAP_LO]};
      strap_valid_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      hs_reg      <= 1'b0;
      stretch_reg <= 1'b0;
    end else if (ce_in) begin
      if (stop_ev) begin
        hs_reg <= 1'b0;
      end else if (ack_fall && in_addr && hs_code) begin
        hs_reg <= 1'b1;
      end
      if (start_ev || stop_ev || (load_tx && tx_ready)) begin
        stretch_reg <= 1'b0;
      end else if (stretch_set) begin
        stretch_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cmd_reg <= iac_pkg::CMD_RESET;
      mux_reg <= '0;
    end else if (ce_in) begin
      if (cmd_done) begin
        cmd_reg <= iac_pkg::iac_cmd_s'({sh_reg[6:0], bit_val});
      end else if (conv_start) begin
        cmd_reg <= iac_pkg::iac_cmd_s'({nib, cmd_reg[3:0]});
      end
      if (conv_start) begin
        mux_reg <= '{pos: pos_sel, neg: neg_sel, neg_common: nib[3]};
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      conv_busy_reg <= 1'b0;
      tim_reg       <= 3'h0;
      sar_reg       <= iac_pkg::RESULT_RESET;
      mask_reg      <= iac_pkg::SAR_FIRST;
      result_reg    <= iac_pkg::RESULT_RESET;
    end else if (ce_in) begin
      if (conv_start) begin
        conv_busy_reg <= 1'b1;
        tim_reg       <= 3'h0;
        sar_reg       <= iac_pkg::SAR_FIRST;
        mask_reg      <= iac_pkg::SAR_FIRST;
      end else if (conv_last) begin
        conv_busy_reg <= 1'b0;
        sar_reg       <= sar_decided;
        result_reg    <= sar_decided;
      end else if (step_end) begin
        tim_reg       <= 3'h0;
        sar_reg       <= sar_decided | (mask_reg >> 1);
        mask_reg      <= mask_reg >> 1;
      end else if (conv_busy_reg) begin
        tim_reg       <= 3'(tim_reg + 3'h1);
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      adc_power_reg <= 1'b0;
      ref_on_reg    <= 1'b0;
      clk_en_reg    <= 1'b0;
    end else if (ce_in) begin
      adc_power_reg <= conv_busy_reg | on_bus | cmd_reg.power_sel_lo;
      ref_on_reg    <= cmd_reg.power_sel_hi;
      clk_en_reg    <= conv_busy_reg;
    end
  end

  assign sda_out         = low_reg;
  assign sda_oe_out      = sda_oe_reg;
  assign scl_out         = low_reg;
  assign scl_oe_out      = stretch_reg;
  assign dac_code_out    = sar_reg;
  assign mux_sel_out     = mux_reg;
  assign adc_power_out   = adc_power_reg;
  assign ref_on_out      = ref_on_reg;
  assign conv_clk_en_out = clk_en_reg;
  assign conv_busy_out   = conv_busy_reg;
  assign hs_mode_out     = hs_reg;

  default clocking chk_cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in || !ce_in);

  start_ready_a: assert property (
    start_ev |=> in_addr && cnt_reg == iac_pkg::CNT_ZERO && !sda_oe_reg)
    else $error("START did not arm the address shifter");

  stop_release_a: assert property (
    stop_ev |=> state_reg == iac_pkg::ST_IDLE && !sda_oe_reg && !hs_reg)
    else $error("STOP did not release the bus");

  ack_match_a: assert property (
    (ack_fall && in_addr && addr_match) |=> sda_oe_reg && !on_bus == 1'b0)
    else $error("Matching address not acknowledged");

  mismatch_quiet_a: assert property (
    (ack_fall && in_addr && !addr_match) |=> state_reg == iac_pkg::ST_IDLE && !sda_oe_reg)
    else $error("Foreign address touched the bus");

  addr_form_a: assert property (
    (ack_fall && in_addr && addr_match) |-> sh_reg[7:1] == 7'(7'h48 + {5'h00, strap_reg}))
    else $error("Address does not follow strap table");

  hs_noack_a: assert property (
    (ack_fall && in_addr && hs_code) |=> hs_reg && !sda_oe_reg)
    else $error("Master code acknowledged or mode not entered");

  strap_once_a: assert property (
    (strap_valid_reg && $past(strap_valid_reg)) |-> $stable(strap_reg))
    else $error("Strap address changed after capture");

  dir_read_a: assert property (
    (ack_fall && in_addr && addr_match) |=> in_read == $past(sh_reg[0]))
    else $error("Direction bit misread");

  conv_early_a: assert property (
    conv_start |-> cnt_reg == iac_pkg::CNT_NIBBLE ##1 conv_busy_reg && sar_reg == 8'h80)
    else $error("Conversion not started after channel bits");

  mux_diff_a: assert property (
    (conv_start && !nib[3]) |=> !mux_reg.neg_common && mux_reg.neg == (mux_reg.pos ^ 3'h1))
    else $error("Differential pair wrong");

  mux_single_a: assert property (
    (conv_start && nib[3]) |=> mux_reg.neg_common && mux_reg.pos[0] == $past(nib[2]))
    else $error("Single-ended input wrong");

  conv_len_a: assert property (
    conv_start |-> ##32 conv_busy_reg ##1 (!conv_busy_reg || $past(conv_start, 33) == 1'b0))
    else $error("Conversion length wrong");

  conv_end_a: assert property (
    $fell(conv_busy_reg) |-> $past(mask_reg) == iac_pkg::SAR_LAST && result_reg == sar_reg)
    else $error("Conversion ended before the last bit");

  stretch_hold_a: assert property (
    (stretch_reg && conv_busy_reg) |=> scl_oe_out)
    else $error("Clock released before result ready");

  msb_first_a: assert property (
    load_tx |=> sda_oe_reg == ~$past(result_reg[7]) && tx_reg == $past(result_reg))
    else $error("Read byte not loaded MSB first");

  gate_off_a: assert property (
    (!conv_busy_reg && !on_bus && !cmd_reg.power_sel_lo) |=> !adc_power_reg && !clk_en_reg)
    else $error("Converter left powered when idle");

  write_cmd_c: cover property (cmd_done);
  read_byte_c: cover property (load_tx ##[1:300] master_nack);
  stretch_c: cover property (stretch_set ##[1:40] load_tx);
  hs_entry_c: cover property (ack_fall && in_addr && hs_code);

endmodule : iac_ctrl

// ### iac_pkg.sv
package iac_pkg;

  // Fixed upper part of the slave address
  localparam logic [4:0] ADDR_PREFIX   = 5'h12;
  // Upper five bits of the high-speed master code
  localparam logic [4:0] HS_CODE_TOP   = 5'h01;

  // Bit counter positions within a nine-pulse byte
  localparam logic [3:0] CNT_ZERO      = 4'h0;
  localparam logic [3:0] CNT_NIBBLE    = 4'h3;
  localparam logic [3:0] CNT_STRAP     = 4'h7;
  localparam logic [3:0] CNT_ACK       = 4'h8;
  localparam logic [3:0] CNT_END       = 4'h9;

  // Approximation step timing
  localparam int         CLK_PERIOD_NS = 25;
  localparam int         STEP_TIME_NS  = 100;
  localparam int         STEP_CYCLES   = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] STEP_LAST     = 3'(STEP_CYCLES - 1);

  // Reset, start and last-step values
  localparam logic [7:0] SAR_FIRST     = 8'h80;
  localparam logic [7:0] SAR_LAST      = 8'h01;
  localparam logic [7:0] RESULT_RESET  = 8'h00;
  localparam logic [7:0] CMD_RESET     = 8'h00;
  localparam logic [5:0] SYNC_RESET    = 6'h03;

  // Synchroniser lanes
  localparam int         SY_SCL        = 0;
  localparam int         SY_SDA        = 1;
  localparam int         SY_CAP        = 2;
  localparam int         SY_STRAP_HI   = 3;
  localparam int         SY_STRAP_LO   = 4;
  localparam int         SY_CMP        = 5;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WRITE,
    ST_READ
  } iac_state_e;

  typedef struct packed {
    logic       input_type_select;
    logic       chan_sel_bit2;
    logic       chan_sel_bit1;
    logic       chan_sel_bit0;
    logic       power_sel_hi;
    logic       power_sel_lo;
    logic [1:0] ignored;
  } iac_cmd_s;

  typedef struct packed {
    logic [2:0] pos;
    logic [2:0] neg;
    logic       neg_common;
  } iac_mux_s;

endpackage : iac_pkg

// ### iac_master.sv
module iac_master (
  output logic      scl_oe_out,
  output logic      sda_oe_out,
  input  wire logic scl_in,
  input  wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
  end

  // Release SCL and wait while the slave stretches it
  task automatic rise_scl;
    int n;
    n = 0;
    scl_oe_out = 1'b0;
    while (scl_in !== 1'b1 && n < 2000) begin
      #64;
      n++;
    end
  endtask : rise_scl

  task automatic send_bit(input logic b);
    #64 sda_oe_out = ~b;
    #128 rise_scl();
    #128 scl_oe_out = 1'b1;
  endtask : send_bit

  task automatic get_bit(output logic b);
    #64 sda_oe_out = 1'b0;
    #128 rise_scl();
    #64 b = sda_in;
    #64 scl_oe_out = 1'b1;
  endtask : get_bit

  // Also serves as repeated start
  task automatic start;
    #64 sda_oe_out = 1'b0;
    #128 rise_scl();
    #128 sda_oe_out = 1'b1;
    #128 scl_oe_out = 1'b1;
  endtask : start

  task automatic stop;
    #64 sda_oe_out = 1'b1;
    #128 rise_scl();
    #128 sda_oe_out = 1'b0;
    #256;
  endtask : stop

  task automatic write_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) send_bit(d[i]);
    get_bit(ack);
  endtask : write_byte

  task automatic read_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    send_bit(last);
  endtask : read_byte
endmodule : iac_master

// ### tb_iac_ctrl.sv
module tb_iac_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV_ADDR = 7'h4A;
  logic              clock_in = 1'b0;
  logic              rst_in   = 1'b1;
  logic              ce_in    = 1'b1;
  logic              strap_hi = 1'b1;
  logic              strap_lo = 1'b0;
  logic              cmp      = 1'b0;
  logic              m_scl_oe, m_sda_oe, d_sda, d_sda_oe, d_scl, d_scl_oe;
  logic [7:0]        dac;
  iac_pkg::iac_mux_s mux;
  logic              adc_pwr, ref_on, clk_en, busy, hs;
  int                fail_count = 0;
  int                n_checks   = 0;
  wire               scl_w = ~(m_scl_oe | d_scl_oe);
  wire               sda_w = ~(m_sda_oe | d_sda_oe);

  always #12.5 clock_in = ~clock_in;
  // Channel-dependent input level
  always @(negedge clock_in) cmp <= ({mux.pos, mux.neg_common, 4'h9} >= dac);

  iac_ctrl u_iac_ctrl (
    .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in), .scl_clk_in(scl_w), .sda_in(sda_w),
    .addr_strap_hi_in(strap_hi), .addr_strap_lo_in(strap_lo), .comparator_in(cmp),
    .sda_out(d_sda), .sda_oe_out(d_sda_oe), .scl_out(d_scl), .scl_oe_out(d_scl_oe),
    .dac_code_out(dac), .mux_sel_out(mux), .adc_power_out(adc_pwr), .ref_on_out(ref_on),
    .conv_clk_en_out(clk_en), .conv_busy_out(busy), .hs_mode_out(hs)
  );

  iac_master u_iac_master (
    .scl_oe_out(m_scl_oe), .sda_oe_out(m_sda_oe), .scl_in(scl_w), .sda_in(sda_w)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  task automatic do_reset(input logic [1:0] s);
    @(negedge clock_in);
    rst_in = 1'b1;
    {strap_hi, strap_lo} = s;
    repeat (5) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clock_in);
  endtask : do_reset

  task automatic addr(input logic [6:0] a, input logic rw, output logic ack);
    u_iac_master.start();
    u_iac_master.write_byte({a, rw}, ack);
  endtask : addr

  task automatic t_reset;
    chk({d_sda | d_scl, d_sda_oe, d_scl_oe, busy, clk_en, ref_on, hs, adc_pwr}, 8'h00, "reset outputs");
    chk(dac, 8'h00, "reset code");
  endtask : t_reset

  task automatic t_strap;
    logic ack;
    for (int s = 0; s < 4; s++) begin
      do_reset(2'(s));
      addr(7'h48 | 7'(s), 1'b0, ack);
      chk(8'(ack), 8'h00, "strap address");
      u_iac_master.stop();
      @(negedge clock_in);
      {strap_hi, strap_lo} = ~2'(s);
      addr(7'h48 | 7'(s), 1'b0, ack);
      chk(8'(ack), 8'h00, "kept address");
      u_iac_master.stop();
      addr(7'h48 | 7'(s ^ 3), 1'b0, ack);
      chk(8'(ack), 8'h01, "foreign address");
      u_iac_master.stop();
    end
    do_reset(2'b10);
  endtask : t_strap

  task automatic t_cmd;
    logic       ack;
    logic [7:0] cmd, d;
    for (int i = 0; i < 16; i++) begin
      cmd = {4'(i), 2'(i), 2'b11};
      addr(DEV_ADDR, 1'b0, ack);
      chk(8'(ack), 8'h00, "write address");
      for (int k = 7; k >= 3; k--) u_iac_master.send_bit(cmd[k]);
      chk({6'h00, busy, clk_en}, 8'h03, "early start");
      for (int k = 2; k >= 0; k--) u_iac_master.send_bit(cmd[k]);
      u_iac_master.get_bit(ack);
      chk(8'(ack), 8'h00, "command ack");
      u_iac_master.stop();
      chk({5'h00, mux.pos}, {5'h00, cmd[5:4], cmd[6]}, "positive input");
      chk(8'(mux.neg_common), 8'(cmd[7]), "common negative");
      if (!cmd[7]) chk({5'h00, mux.neg}, {5'h00, cmd[5:4], ~cmd[6]}, "negative input");
      chk(8'(ref_on), 8'(cmd[3]), "reference");
      chk({6'h00, adc_pwr, clk_en | busy}, {6'h00, cmd[2], 1'b0}, "idle power");
      addr(DEV_ADDR, 1'b1, ack);
      chk(8'(ack), 8'h00, "read address");
      u_iac_master.read_byte(1'b1, d);
      u_iac_master.stop();
      chk(d, {cmd[5:4], cmd[6], cmd[7], 4'h9}, "result");
    end
  endtask : t_cmd

  task automatic t_multi;
    logic       ack;
    logic [7:0] d;
    addr(DEV_ADDR, 1'b0, ack);
    u_iac_master.write_byte(8'hF4, ack);
    chk(8'(ack), 8'h00, "first command");
    u_iac_master.write_byte(8'h2C, ack);
    chk(8'(ack), 8'h00, "second command");
    addr(DEV_ADDR, 1'b1, ack);
    chk(8'(ack), 8'h00, "restart read");
    for (int j = 0; j < 3; j++) begin
      u_iac_master.read_byte(j == 2, d);
      chk(d, 8'h89, "repeated read");
    end
    u_iac_master.stop();
    chk(8'(ref_on), 8'h01, "reference kept");
  endtask : t_multi

  task automatic t_freeze;
    logic       ack;
    logic [7:0] cmd, d;
    cmd = 8'h2C;
    addr(DEV_ADDR, 1'b0, ack);
    for (int k = 7; k >= 4; k--) u_iac_master.send_bit(cmd[k]);
    // Conversion running; freeze longer than a whole conversion
    @(negedge clock_in);
    ce_in = 1'b0;
    repeat (40) @(negedge clock_in);
    chk({6'h00, busy, clk_en}, 8'h03, "frozen conversion");
    ce_in = 1'b1;
    for (int k = 3; k >= 0; k--) u_iac_master.send_bit(cmd[k]);
    u_iac_master.get_bit(ack);
    chk(8'(ack), 8'h00, "command after freeze");
    u_iac_master.stop();
    addr(DEV_ADDR, 1'b1, ack);
    u_iac_master.read_byte(1'b1, d);
    u_iac_master.stop();
    chk(d, 8'h89, "result after freeze");
  endtask : t_freeze

  task automatic t_hs;
    logic       ack;
    logic [7:0] d;
    u_iac_master.start();
    u_iac_master.write_byte(8'h0B, ack);
    chk(8'(ack), 8'h01, "master code");
    chk(8'(hs), 8'h01, "high speed entry");
    addr(DEV_ADDR, 1'b1, ack);
    chk(8'(ack), 8'h00, "high speed address");
    u_iac_master.read_byte(1'b1, d);
    chk(d, 8'h89, "stored result");
    chk(8'(hs), 8'h01, "high speed kept");
    u_iac_master.stop();
    chk(8'(hs), 8'h00, "high speed left");
  endtask : t_hs

  initial begin
    do_reset(2'b10);
    t_reset();
    t_strap();
    t_cmd();
    t_multi();
    t_freeze();
    t_hs();
    tally_and_finish();
  end

  initial begin
    #1ms;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule : tb_iac_ctrl
